/* src/pxlu_params.svh */
// Constants for the exclusive-OR / exclusive-OR-NOT logic unit
`ifndef PXLU_PARAMS_SVH
`define PXLU_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and masks
// ----------------------------------------------------------------
`define PXLU_WORD_W      32
`define PXLU_MASK_BYTE   32'h0000_00ff
`define PXLU_MASK_WORD   32'h0000_ffff
`define PXLU_MASK_DWORD  32'hffff_ffff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PXLU_LOGIC_ACC_RST 1'h0
`define PXLU_WORD_ACC_RST  32'h0000_0000

`endif

/* src/pxlu_pkg.sv */
// Types and the shared width_mask function of the exclusive-OR logic unit
`include "pxlu_params.svh"
package pxlu_pkg;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      pxlu_op_nop      = 3'h0,
      pxlu_op_ld_bit   = 3'h1,
      pxlu_op_ldn_bit  = 3'h2,
      pxlu_op_xo_bit   = 3'h3,
      pxlu_op_xon_bit  = 3'h4,
      pxlu_op_ld_word  = 3'h5,
      pxlu_op_xo_word  = 3'h6,
      pxlu_op_xon_word = 3'h7
   } pxlu_op_t;

   // ----------------------------------------------------------------
   // Operand sizes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      pxlu_sz_byte  = 2'h0,
      pxlu_sz_word  = 2'h1,
      pxlu_sz_dword = 2'h2,
      pxlu_sz_const = 2'h3
   } pxlu_size_t;

   typedef enum logic [1:0] {
      pxlu_gate_load = 2'h0,
      pxlu_gate_xor  = 2'h1,
      pxlu_gate_xnor = 2'h2
   } pxlu_gate_t;

   typedef enum logic {
      pxlu_chain_idle = 1'b0,
      pxlu_chain_open = 1'b1
   } pxlu_chain_t;

   // Accumulator bits touched by an operand size
   function automatic logic [`PXLU_WORD_W-1:0] width_mask(
      input pxlu_size_t sz);
      case (sz)
         pxlu_sz_byte:  width_mask = `PXLU_MASK_BYTE;
         pxlu_sz_word:  width_mask = `PXLU_MASK_WORD;
         default:       width_mask = `PXLU_MASK_DWORD;
      endcase
   endfunction

endpackage

/* src/pxlu_word_gate.sv */
// Bitwise word gate: load, XOR or XNOR under an operand-size mask
`timescale 1ns/1ps
`include "pxlu_params.svh"
module pxlu_word_gate (
   // Control
   input  pxlu_pkg::pxlu_gate_t    gate,
   input  pxlu_pkg::pxlu_size_t    size,
   // Data
   input  logic [`PXLU_WORD_W-1:0] acc,
   input  logic [`PXLU_WORD_W-1:0] operand,
   output logic [`PXLU_WORD_W-1:0] result
);

   logic [`PXLU_WORD_W-1:0] mask;

   always_comb begin
      mask = pxlu_pkg::width_mask(size);
      case (gate)
         // Zero-fill above the operand
         pxlu_pkg::pxlu_gate_load: result = operand & mask;
         // Same bit index on both sides, untouched bits kept
         pxlu_pkg::pxlu_gate_xor:
            result = (acc & ~mask) | ((acc ^ operand) & mask);
         pxlu_pkg::pxlu_gate_xnor:
            result = (acc & ~mask) | (~(acc ^ operand) & mask);
         default: result = acc;
      endcase
   end

endmodule

/* src/pxlu_logic_unit.sv */
// Exclusive-OR / exclusive-OR-NOT datapath with logic and word accumulators
`timescale 1ns/1ps
`include "pxlu_params.svh"
module pxlu_logic_unit (
   // Clock, reset, enable
   input  logic                    core_clk,
   input  logic                    rstn,
   input  logic                    clk_en,
   // Instruction from the sequencer
   input  logic                    instr_valid,
   input  pxlu_pkg::pxlu_op_t      instr_op,
   input  pxlu_pkg::pxlu_size_t    instr_size,
   input  logic                    bit_operand,
   input  logic [`PXLU_WORD_W-1:0] word_operand,
   input  logic                    chain_close,
   // Accumulators and status
   output logic                    logic_acc_ff,
   output logic [`PXLU_WORD_W-1:0] word_acc_ff,
   output logic                    chain_open_ff,
   output logic                    done_ff
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pxlu_pkg::pxlu_chain_t   chain_ff;
   pxlu_pkg::pxlu_chain_t   nxt_chain;
   pxlu_pkg::pxlu_gate_t    word_gate;
   logic [`PXLU_WORD_W-1:0] word_result;
   logic                    nxt_logic_acc;
   logic [`PXLU_WORD_W-1:0] nxt_word_acc;
   logic                    nxt_chain_open;
   logic                    nxt_done;
   logic                    take;
   logic                    first_in_chain;

   assign take           = clk_en & instr_valid;
   assign first_in_chain = (chain_ff == pxlu_pkg::pxlu_chain_idle);

   // ----------------------------------------------------------------
   // Word path
   // ----------------------------------------------------------------
   always_comb begin
      case (instr_op)
         pxlu_pkg::pxlu_op_ld_word:  word_gate = pxlu_pkg::pxlu_gate_load;
         pxlu_pkg::pxlu_op_xo_word:  word_gate = pxlu_pkg::pxlu_gate_xor;
         pxlu_pkg::pxlu_op_xon_word: word_gate = pxlu_pkg::pxlu_gate_xnor;
         default:                    word_gate = pxlu_pkg::pxlu_gate_xor;
      endcase
   end

   pxlu_word_gate u_word_gate (
      .gate    (word_gate),
      .size    (instr_size),
      .acc     (word_acc_ff),
      .operand (word_operand),
      .result  (word_result)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_logic_acc = logic_acc_ff;
      nxt_word_acc  = word_acc_ff;
      nxt_chain     = chain_ff;
      nxt_done      = take;
      if (take) begin
         case (instr_op)
            pxlu_pkg::pxlu_op_ld_bit: begin
               nxt_logic_acc = bit_operand;
               nxt_chain     = pxlu_pkg::pxlu_chain_open;
            end
            pxlu_pkg::pxlu_op_ldn_bit: begin
               nxt_logic_acc = ~bit_operand;
               nxt_chain     = pxlu_pkg::pxlu_chain_open;
            end
            pxlu_pkg::pxlu_op_xo_bit: begin
               if (first_in_chain) begin
                  nxt_logic_acc = bit_operand;
               end else begin
                  nxt_logic_acc = logic_acc_ff ^ bit_operand;
               end
               nxt_chain = pxlu_pkg::pxlu_chain_open;
            end
            pxlu_pkg::pxlu_op_xon_bit: begin
               if (first_in_chain) begin
                  nxt_logic_acc = ~bit_operand;
               end else begin
                  nxt_logic_acc = ~(logic_acc_ff ^ bit_operand);
               end
               nxt_chain = pxlu_pkg::pxlu_chain_open;
            end
            // Word forms leave the logic accumulator alone
            pxlu_pkg::pxlu_op_ld_word,
            pxlu_pkg::pxlu_op_xo_word,
            pxlu_pkg::pxlu_op_xon_word: begin
               nxt_word_acc = word_result;
            end
            default: begin
               nxt_done = 1'b0;
            end
         endcase
      end
      // Closing wins: the instruction of this cycle still counts
      if (clk_en && chain_close) begin
         nxt_chain = pxlu_pkg::pxlu_chain_idle;
      end
      nxt_chain_open = (nxt_chain == pxlu_pkg::pxlu_chain_open);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         logic_acc_ff  <= `PXLU_LOGIC_ACC_RST;
         word_acc_ff   <= `PXLU_WORD_ACC_RST;
         chain_ff      <= pxlu_pkg::pxlu_chain_idle;
         chain_open_ff <= 1'b0;
         done_ff       <= 1'b0;
      end else if (clk_en) begin
         logic_acc_ff  <= nxt_logic_acc;
         word_acc_ff   <= nxt_word_acc;
         chain_ff      <= nxt_chain;
         chain_open_ff <= nxt_chain_open;
         done_ff       <= nxt_done;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_first_bit(pxlu_pkg::pxlu_op_t op);
      take && instr_op == op && first_in_chain;
   endsequence

   sequence s_chain_bit(pxlu_pkg::pxlu_op_t op);
      take && instr_op == op && !first_in_chain;
   endsequence

   sequence s_word_op(pxlu_pkg::pxlu_op_t op, pxlu_pkg::pxlu_size_t sz);
      take && instr_op == op && instr_size == sz;
   endsequence

   sequence s_quiet;
      !instr_valid;
   endsequence

   first_xo_load_a: assert property (
      s_first_bit(pxlu_pkg::pxlu_op_xo_bit)
      |=> logic_acc_ff == $past(bit_operand)
         && (chain_open_ff || $past(chain_close)))
      else $error("Opening exclusive-OR did not load operand");

   chain_xo_a: assert property (
      s_chain_bit(pxlu_pkg::pxlu_op_xo_bit)
      |=> logic_acc_ff == ($past(logic_acc_ff) ^ $past(bit_operand)))
      else $error("Chained exclusive-OR gave wrong logic result");

   first_xon_load_a: assert property (
      s_first_bit(pxlu_pkg::pxlu_op_xon_bit)
      |=> logic_acc_ff == !$past(bit_operand))
      else $error("Opening exclusive-OR-NOT did not load complement");

   chain_xon_a: assert property (
      s_chain_bit(pxlu_pkg::pxlu_op_xon_bit)
      |=> logic_acc_ff == !($past(logic_acc_ff) ^ $past(bit_operand)))
      else $error("Chained exclusive-OR-NOT gave wrong logic result");

   dword_xor_a: assert property (
      s_word_op(pxlu_pkg::pxlu_op_xo_word, pxlu_pkg::pxlu_sz_dword)
      |=> word_acc_ff == ($past(word_acc_ff) ^ $past(word_operand)))
      else $error("Doubleword exclusive-OR result wrong");

   byte_upper_keep_a: assert property (
      s_word_op(pxlu_pkg::pxlu_op_xo_word, pxlu_pkg::pxlu_sz_byte)
      |=> word_acc_ff[31:8] == $past(word_acc_ff[31:8])
         && word_acc_ff[7:0]
            == ($past(word_acc_ff[7:0]) ^ $past(word_operand[7:0])))
      else $error("Byte exclusive-OR touched wrong bits");

   bit_pairing_a: assert property (
      s_word_op(pxlu_pkg::pxlu_op_xo_word, pxlu_pkg::pxlu_sz_word)
      |=> word_acc_ff[0] == ($past(word_acc_ff[0]) ^ $past(word_operand[0]))
         && word_acc_ff[15]
            == ($past(word_acc_ff[15]) ^ $past(word_operand[15])))
      else $error("Word bits paired with the wrong operand bits");

   result_kept_a: assert property (
      s_word_op(pxlu_pkg::pxlu_op_xo_word, pxlu_pkg::pxlu_sz_const)
      ##1 s_quiet
      |=> word_acc_ff == ($past(word_acc_ff, 2) ^ $past(word_operand, 2)))
      else $error("Word result not held in the accumulator");

   word_xnor_a: assert property (
      s_word_op(pxlu_pkg::pxlu_op_xon_word, pxlu_pkg::pxlu_sz_word)
      |=> word_acc_ff[15:0]
            == ~($past(word_acc_ff[15:0]) ^ $past(word_operand[15:0]))
         && word_acc_ff[31:16] == $past(word_acc_ff[31:16]))
      else $error("Word exclusive-OR-NOT result wrong");

   xon_logic_keep_a: assert property (
      take && instr_op == pxlu_pkg::pxlu_op_xon_word
      |=> $stable(logic_acc_ff))
      else $error("Word exclusive-OR-NOT changed the logic accumulator");

   load_zero_fill_a: assert property (
      s_word_op(pxlu_pkg::pxlu_op_ld_word, pxlu_pkg::pxlu_sz_byte)
      |=> word_acc_ff == {24'h00_0000, $past(word_operand[7:0])})
      else $error("Byte load did not zero-fill the accumulator");

endmodule

/* verif/pxlu_seq_model.sv */
// Instruction sequencer model that feeds the logic unit
`timescale 1ns/1ps
module pxlu_seq_model (
   // Clock
   input  logic                 core_clk,
   // Instruction to the unit
   output logic                 clk_en,
   output logic                 instr_valid,
   output pxlu_pkg::pxlu_op_t   instr_op,
   output pxlu_pkg::pxlu_size_t instr_size,
   output logic                 bit_operand,
   output logic [31:0]          word_operand,
   output logic                 chain_close
);
   initial begin
      clk_en = 1'b1;
      instr_valid = 1'b0;
      instr_op = pxlu_pkg::pxlu_op_nop;
      instr_size = pxlu_pkg::pxlu_sz_byte;
      bit_operand = 1'b0;
      word_operand = 32'h0000_0000;
      chain_close = 1'b0;
   end

   // Hold request through gap stalled edges, taken on the next enabled one
   task automatic issue(input logic [2:0] op, input logic [1:0] sz,
                        input logic b, input logic [31:0] w,
                        input logic cl, input int gap);
      instr_valid = 1'b1;
      instr_op = pxlu_pkg::pxlu_op_t'(op);
      instr_size = pxlu_pkg::pxlu_size_t'(sz);
      bit_operand = b;
      word_operand = w;
      chain_close = cl;
      clk_en = (gap == 0);
      repeat (gap) @(posedge core_clk);
      if (gap != 0) begin
         #1;
         clk_en = 1'b1;
      end
      @(posedge core_clk);
      #1;
   endtask

   // Released operands show changed values, never the last ones
   task automatic idle();
      instr_valid = 1'b0;
      chain_close = 1'b0;
      bit_operand = ~bit_operand;
      word_operand = ~word_operand;
   endtask
endmodule

/* verif/plc_xor_xnor_logic_unit_tb.sv */
// Self-checking bench of the exclusive-OR logic unit
`timescale 1ns/1ps
`define PXLU_CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
   errors++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module plc_xor_xnor_logic_unit_tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic clk_en, instr_valid, bit_operand, chain_close;
   logic logic_acc_ff, chain_open_ff, done_ff;
   logic [31:0] word_operand, word_acc_ff, rnd;
   pxlu_pkg::pxlu_op_t   instr_op;
   pxlu_pkg::pxlu_size_t instr_size;
   logic [33:0] expq[$];
   logic [33:0] exp_v;
   logic        en_s;
   logic        m_lacc = 1'b0;
   logic        m_open = 1'b0;
   logic [31:0] m_wacc = 32'h0000_0000;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;

   always #2.5 core_clk = ~core_clk;

   pxlu_seq_model seq (.core_clk(core_clk), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_size(instr_size), .bit_operand(bit_operand),
      .word_operand(word_operand), .chain_close(chain_close));

   pxlu_logic_unit uut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_size(instr_size), .bit_operand(bit_operand),
      .word_operand(word_operand), .chain_close(chain_close),
      .logic_acc_ff(logic_acc_ff), .word_acc_ff(word_acc_ff),
      .chain_open_ff(chain_open_ff), .done_ff(done_ff));

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // ------------------------------------------------------------
   // Reference model and driver
   // ------------------------------------------------------------
   task automatic send(input logic [2:0] op, input logic [1:0] sz,
                       input logic b, input logic [31:0] w,
                       input logic cl, input int gap);
      logic [31:0] m;
      m = (sz == 2'h0) ? 32'h0000_00ff :
          (sz == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
      case (op)
         3'h1: m_lacc = b;
         3'h2: m_lacc = ~b;
         3'h3: m_lacc = m_open ? (m_lacc ^ b) : b;
         3'h4: m_lacc = m_open ? ~(m_lacc ^ b) : ~b;
         3'h5: m_wacc = w & m;
         3'h6: m_wacc = (m_wacc & ~m) | ((m_wacc ^ w) & m);
         3'h7: m_wacc = (m_wacc & ~m) | (~(m_wacc ^ w) & m);
         default: ;
      endcase
      if (op inside {[3'h1:3'h4]}) m_open = 1'b1;
      if (cl) m_open = 1'b0;
      if (op != 3'h0) expq.push_back({m_open, m_lacc, m_wacc});
      seq.issue(op, sz, b, w, cl, gap);
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Result watcher and hang guard
   // ------------------------------------------------------------
   // A stalled edge freezes done_ff, so only enabled edges give results
   always @(posedge core_clk) begin
      en_s = clk_en;
      #1;
      if (done_ff === 1'b1 && en_s === 1'b1) begin
         if (expq.size() == 0) begin
            `PXLU_CHK(done_ff, 1'b0)
         end else begin
            exp_v = expq.pop_front();
            `PXLU_CHK({chain_open_ff, logic_acc_ff, word_acc_ff}, exp_v)
         end
      end
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
   end

   initial begin
      rnd = 32'he7ad9d0c;
      repeat (5) @(posedge core_clk);
      #1;
      `PXLU_CHK({chain_open_ff, logic_acc_ff, word_acc_ff, done_ff}, 35'h0)
      rstn = 1'b1;
      send(3'h3, 2'h0, 1'b1, 32'h0, 1'b0, 0);
      send(3'h3, 2'h0, 1'b1, 32'h0, 1'b0, 0);
      send(3'h4, 2'h0, 1'b0, 32'h0, 1'b1, 0);
      send(3'h4, 2'h0, 1'b1, 32'h0, 1'b0, 2);
      send(3'h4, 2'h0, 1'b1, 32'h0, 1'b1, 0);
      send(3'h5, 2'h0, 1'b0, 32'hffff_ff36, 1'b0, 0);
      send(3'h6, 2'h0, 1'b0, 32'h1234_562a, 1'b0, 1);
      send(3'h5, 2'h1, 1'b0, 32'habcd_3c36, 1'b0, 0);
      send(3'h7, 2'h1, 1'b1, 32'h0000_36aa, 1'b0, 0);
      for (int s = 0; s < 4; s++) begin
         rnd = lfsr_next(rnd);
         send(3'h6, s[1:0], 1'b0, rnd, 1'b0, 0);
         rnd = lfsr_next(rnd);
         send(3'h7, s[1:0], 1'b0, rnd, 1'b0, 0);
      end
      send(3'h5, 2'h3, 1'b0, 32'h8000_0001, 1'b0, 0);
      send(3'h6, 2'h2, 1'b0, 32'h0000_0001, 1'b0, 0);
      for (int i = 0; i < 300; i++) begin
         logic [2:0] op;
         rnd = lfsr_next(rnd);
         op = rnd[2:0];
         if (!m_open && (op == 3'h3 || op == 3'h4)) op = op - 3'h2;
         send(op, rnd[4:3], rnd[5], lfsr_next(rnd), rnd[7:6] == 2'h0,
              int'(rnd[9:8] == 2'h0));
         if (rnd[10]) begin
            seq.idle();
            @(posedge core_clk);
            #1;
         end
      end
      seq.idle();
      repeat (3) @(posedge core_clk);
      `PXLU_CHK(expq.size(), 0)
      complete_run();
   end
endmodule
